/* src/gas_out_params.svh */
// timing, protocol and character constants of the gas sensor output block
`ifndef GAS_OUT_PARAMS_SVH
`define GAS_OUT_PARAMS_SVH
`define CLK_HZ 100000000
`define MS_PER_S 1000
`define UART_BAUD 38400
`define FRAME_PERIOD_MS 3000
`define PWM_PERIOD_MS 2000
`define PWM_START_MS 2
`define PWM_SPAN_MS 1000
`define UART_BITS 10
`define PCT_LEN 4'h9
`define PPM_LEN 4'hC
`define PCT_MAX 16'h270F
`define PPM_PER_COUNT 8'h64
`define I2C_ADDR 7'h31
`define I2C_CMD_READ 8'h52
`define I2C_RESP_LEN 3'h7
`define I2C_CFG_BYTE 8'h08
`define CH_SP 8'h20
`define CH_ZERO 8'h30
`define CH_DOT 8'h2E
`define CH_PCT 8'h25
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_P 8'h70
`define CH_M 8'h6D
`define RANGE_2K 17'h007D0
`define RANGE_3K 17'h00BB8
`define RANGE_5K 17'h01388
`define RANGE_10K 17'h02710
`endif

/* src/gas_out_pkg.sv */
// types shared by the gas sensor output block
package gas_out_pkg;
  // new measurement, concentration in hundredths of a percent
  typedef struct packed {
    logic valid;
    logic [15:0] conc;
  } sample_s;
  typedef struct packed {
    logic [1:0] range_sel;
    logic range_x10;
  } pwm_cfg_s;
  typedef struct packed {
    logic [23:0] on_ppm;
    logic [23:0] off_ppm;
  } alarm_cfg_s;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WR, I_ACK, I_RD, I_RACK} i2c_state_e;
  typedef enum logic {U_IDLE, U_SEND} uart_state_e;
endpackage

/* src/gas_out_top.sv */
// uart frames, i2c slave, pwm and alarm outputs of the gas sensor
`timescale 1ns/100ps
`include "gas_out_params.svh"

// Functional notes
// - uart frame every 3 s, unrequested
// - ppm_mode input picks ppm or percent
// - percent frame: dd.dd, space, %, cr, lf
// - tens digit zero sent as space
// - ppm frame: six digits, space, ppm, cr, lf
// - leading ppm zeros sent as spaces
// - i2c slave only at address 0x31
// - address lsb one reads, zero writes
// - i2c value in hundredths of percent
// - pwm high 2 ms plus span times ratio
// - pwm period fixed at 2000 ms
// - pwm range 2k/3k/5k/10k, optional x10
// - alarm off at reset, hysteresis on/off
// - alarm pin open collector, sinks when active
// - alarm thresholds come from input settings
// - uart 38400 baud, 8n1
module gas_out_top #(
  parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S,
  parameter int FRAME_MS = `FRAME_PERIOD_MS,
  parameter int PWM_SPAN = `PWM_SPAN_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire gas_out_pkg::sample_s sample,
  input wire logic ppm_mode,
  input wire gas_out_pkg::pwm_cfg_s pwm_cfg,
  input wire gas_out_pkg::alarm_cfg_s alarm_cfg,
  output logic uart_txd,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic pwm_out,
  output logic alarm_o,
  output logic alarm_oe
);
  import gas_out_pkg::*;

  localparam int BAUD_DIV = `CLK_HZ / `UART_BAUD;
  localparam int NUM_W = 36;

  function automatic logic [15:0] to_bcd(input logic [15:0] v);
    logic [31:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 4; j++) begin
        if (s[16 + 4 * j +: 4] > 4'h4) begin
          s[16 + 4 * j +: 4] = s[16 + 4 * j +: 4] + 4'h3;
        end
      end
      s = {s[30:0], 1'b0};
    end
    return s[31:16];
  endfunction

  function automatic logic [7:0] dig(input logic [3:0] d, input logic blank);
    return blank ? `CH_SP : (`CH_ZERO | {4'h0, d});
  endfunction

  function automatic logic [7:0] frame_byte(input logic [3:0] idx, input logic ppm,
                                            input logic [15:0] b);
    logic z4, z3, z2, z1;
    logic [7:0] r;
    z4 = b[15:12] == 4'h0;
    z3 = z4 && b[11:8] == 4'h0;
    z2 = z3 && b[7:4] == 4'h0;
    z1 = z2 && b[3:0] == 4'h0;
    r = `CH_SP;
    if (!ppm) begin
      case (idx)
        4'h0: r = dig(b[15:12], z4);
        4'h1: r = dig(b[11:8], 1'b0);
        4'h2: r = `CH_DOT;
        4'h3: r = dig(b[7:4], 1'b0);
        4'h4: r = dig(b[3:0], 1'b0);
        4'h6: r = `CH_PCT;
        4'h7: r = `CH_CR;
        4'h8: r = `CH_LF;
        default: r = `CH_SP;
      endcase
    end else begin
      // ppm digits are the count digits followed by two zeros
      case (idx)
        4'h0: r = dig(b[15:12], z4);
        4'h1: r = dig(b[11:8], z3);
        4'h2: r = dig(b[7:4], z2);
        4'h3: r = dig(b[3:0], z1);
        4'h4: r = dig(4'h0, z1);
        4'h5: r = dig(4'h0, 1'b0);
        4'h7: r = `CH_P;
        4'h8: r = `CH_P;
        4'h9: r = `CH_M;
        4'hA: r = `CH_CR;
        4'hB: r = `CH_LF;
        default: r = `CH_SP;
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sample capture, shared by every output
  logic [15:0] conc_r;
  logic [15:0] bcd_r;
  logic [23:0] ppm_r;
  logic new_r;
  wire [15:0] conc_clamped = (conc_r > `PCT_MAX) ? `PCT_MAX : conc_r;
  wire [23:0] ppm_nxt = 24'(sample.conc * `PPM_PER_COUNT);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conc_r <= 16'h0000;
      ppm_r <= 24'h000000;
      bcd_r <= 16'h0000;
      new_r <= 1'b0;
    end else begin
      new_r <= sample.valid;
      bcd_r <= to_bcd(conc_clamped);
      if (sample.valid) begin
        conc_r <= sample.conc;
        ppm_r <= ppm_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick, frame timer and pwm
  logic [31:0] ms_div_r;
  logic [15:0] frame_ms_r;
  logic [15:0] pwm_ms_r;
  logic [15:0] high_r;
  logic [15:0] high_act_r;
  wire ms_tick = ms_div_r == 32'(MS_CYCLES - 1);
  wire frame_due = ms_tick && frame_ms_r == 16'(FRAME_MS - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_r <= 32'h0;
      frame_ms_r <= 16'h0000;
      pwm_ms_r <= 16'h0000;
      high_act_r <= 16'(`PWM_START_MS);
      pwm_out <= 1'b0;
    end else begin
      ms_div_r <= ms_tick ? 32'h0 : ms_div_r + 32'h1;
      if (ms_tick) begin
        frame_ms_r <= frame_due ? 16'h0000 : frame_ms_r + 16'h0001;
        if (pwm_ms_r == 16'(`PWM_PERIOD_MS - 1)) begin
          pwm_ms_r <= 16'h0000;
          high_act_r <= high_r; // new width only at a period boundary, no runt pulses
        end else begin
          pwm_ms_r <= pwm_ms_r + 16'h0001;
        end
      end
      pwm_out <= pwm_ms_r < high_act_r;
    end
  end

  // range lookup
  logic [16:0] range_base;
  always_comb begin
    case (pwm_cfg.range_sel)
      2'h0: range_base = `RANGE_2K;
      2'h1: range_base = `RANGE_3K;
      2'h2: range_base = `RANGE_5K;
      default: range_base = `RANGE_10K;
    endcase
  end
  wire [16:0] range_ppm = pwm_cfg.range_x10 ? 17'(range_base * 4'hA) : range_base;

  // serial divider: span * ppm / range, one bit per cycle
  logic [NUM_W-1:0] quo_r;
  logic [17:0] rem_r;
  logic [5:0] div_cnt_r;
  logic [16:0] den_r;
  wire [17:0] rem_try = {rem_r[16:0], quo_r[NUM_W-1]};
  wire rem_ge = rem_try >= {1'b0, den_r};
  wire [NUM_W-1:0] span_w = NUM_W'(PWM_SPAN);
  wire [NUM_W-1:0] q_clamp = (quo_r > span_w) ? span_w : quo_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quo_r <= '0;
      rem_r <= 18'h00000;
      den_r <= 17'h00001;
      div_cnt_r <= 6'h00;
      high_r <= 16'(`PWM_START_MS);
    end else if (new_r) begin
      quo_r <= NUM_W'(ppm_r * span_w);
      den_r <= range_ppm;
      rem_r <= 18'h00000;
      div_cnt_r <= 6'(NUM_W);
    end else if (div_cnt_r != 6'h00) begin
      rem_r <= rem_ge ? rem_try - {1'b0, den_r} : rem_try;
      quo_r <= {quo_r[NUM_W-2:0], rem_ge};
      div_cnt_r <= div_cnt_r - 6'h01;
      if (div_cnt_r == 6'h01) begin
        high_r <= 16'(`PWM_START_MS) + 16'({q_clamp[NUM_W-2:0], rem_ge} > span_w ?
                  span_w : {q_clamp[NUM_W-2:0], rem_ge});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm with hysteresis, open collector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_oe <= 1'b0;
      alarm_o <= 1'b0;
    end else if (new_r) begin
      if (ppm_r >= alarm_cfg.on_ppm) begin
        alarm_oe <= 1'b1;
      end else if (ppm_r <= alarm_cfg.off_ppm) begin
        alarm_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // uart transmitter; frame content frozen at frame start
  uart_state_e u_state_r;
  logic [15:0] u_bcd_r;
  logic u_ppm_r;
  logic [3:0] u_idx_r;
  logic [3:0] u_bit_r;
  logic [15:0] u_baud_r;
  logic [9:0] u_sh_r;
  wire u_baud_end = u_baud_r == 16'(BAUD_DIV - 1);
  wire [3:0] u_len = u_ppm_r ? `PPM_LEN : `PCT_LEN;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      u_state_r <= U_IDLE;
      u_bcd_r <= 16'h0000;
      u_ppm_r <= 1'b0;
      u_idx_r <= 4'h0;
      u_bit_r <= 4'h0;
      u_baud_r <= 16'h0000;
      u_sh_r <= 10'h3FF;
      uart_txd <= 1'b1;
    end else begin
      case (u_state_r)
        U_IDLE: begin
          uart_txd <= 1'b1;
          if (frame_due) begin
            u_bcd_r <= bcd_r;
            u_ppm_r <= ppm_mode;
            u_idx_r <= 4'h0;
            u_bit_r <= 4'h0;
            u_baud_r <= 16'h0000;
            u_sh_r <= {1'b1, frame_byte(4'h0, ppm_mode, bcd_r), 1'b0};
            u_state_r <= U_SEND;
          end
        end
        U_SEND: begin
          uart_txd <= u_sh_r[0];
          u_baud_r <= u_baud_end ? 16'h0000 : u_baud_r + 16'h0001;
          if (u_baud_end) begin
            if (u_bit_r == 4'(`UART_BITS - 1)) begin
              u_bit_r <= 4'h0;
              u_idx_r <= u_idx_r + 4'h1;
              u_sh_r <= {1'b1, frame_byte(u_idx_r + 4'h1, u_ppm_r, u_bcd_r), 1'b0};
              if (u_idx_r == u_len - 4'h1) begin
                u_state_r <= U_IDLE;
              end
            end else begin
              u_bit_r <= u_bit_r + 4'h1;
              u_sh_r <= {1'b1, u_sh_r[9:1]};
            end
          end
        end
        default: u_state_r <= U_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i2c slave
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3F;
    end else begin
      {scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
    end
  end
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire i2c_start = scl_s && scl_q && sda_q && !sda_s;
  wire i2c_stop = scl_s && scl_q && !sda_q && sda_s;

  i2c_state_e i_state_r;
  logic [7:0] i_sh_r;
  logic [3:0] i_cnt_r;
  logic i_rw_r;
  logic i_nack_r;
  logic [2:0] i_idx_r;
  logic [15:0] i_snap_r;
  logic cmd_seen_r;
  logic [7:0] resp_byte;
  always_comb begin
    case (i_idx_r)
      3'h0: resp_byte = `I2C_CFG_BYTE;
      3'h1: resp_byte = i_snap_r[15:8];
      3'h2: resp_byte = i_snap_r[7:0];
      default: resp_byte = 8'h00;
    endcase
  end

  // byte after the current one, so the first bit can be driven on the same scl fall
  logic [7:0] resp_byte_next;
  always_comb begin
    case (i_idx_r + 3'h1)
      3'h1: resp_byte_next = i_snap_r[15:8];
      3'h2: resp_byte_next = i_snap_r[7:0];
      default: resp_byte_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i_state_r <= I_IDLE;
      i_sh_r <= 8'h00;
      i_cnt_r <= 4'h0;
      i_rw_r <= 1'b0;
      i_nack_r <= 1'b0;
      i_idx_r <= 3'h0;
      i_snap_r <= 16'h0000;
      cmd_seen_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (i2c_stop) begin
      i_state_r <= I_IDLE;
      sda_oe <= 1'b0;
    end else if (i2c_start) begin
      i_state_r <= I_ADDR;
      i_cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      case (i_state_r)
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            i_sh_r <= {i_sh_r[6:0], sda_s};
            i_cnt_r <= i_cnt_r + 4'h1;
          end else if (scl_fall && i_cnt_r == 4'h8) begin
            if (i_state_r == I_WR) begin
              cmd_seen_r <= i_sh_r == `I2C_CMD_READ;
              sda_oe <= 1'b1;
              i_state_r <= I_ACK;
            end else if (i_sh_r[7:1] == `I2C_ADDR) begin
              i_rw_r <= i_sh_r[0];
              sda_oe <= 1'b1;
              i_idx_r <= 3'h0;
              i_snap_r <= conc_r; // one snapshot keeps the value bytes coherent
              i_state_r <= I_ACK;
            end else begin
              i_state_r <= I_IDLE;
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            i_cnt_r <= 4'h0;
            if (i_rw_r) begin
              i_sh_r <= resp_byte;
              sda_oe <= !resp_byte[7];
              i_state_r <= I_RD;
            end else begin
              sda_oe <= 1'b0;
              i_state_r <= I_WR;
            end
          end
        end
        I_RD: begin
          if (scl_fall) begin
            if (i_cnt_r == 4'h7) begin
              sda_oe <= 1'b0;
              i_state_r <= I_RACK;
            end else begin
              sda_oe <= !i_sh_r[6];
              i_sh_r <= {i_sh_r[6:0], 1'b0};
              i_cnt_r <= i_cnt_r + 4'h1;
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            i_nack_r <= sda_s;
          end else if (scl_fall) begin
            if (i_nack_r) begin
              i_state_r <= I_IDLE;
            end else begin
              i_idx_r <= (i_idx_r == `I2C_RESP_LEN - 3'h1) ? i_idx_r : i_idx_r + 3'h1;
              i_cnt_r <= 4'h0;
              i_sh_r <= (i_idx_r == `I2C_RESP_LEN - 3'h1) ? 8'h00 : resp_byte_next;
              sda_oe <= !((i_idx_r == `I2C_RESP_LEN - 3'h1) ? 1'b0 : resp_byte_next[7]);
              i_state_r <= I_RD;
            end
          end
        end
        default: i_state_r <= I_IDLE;
      endcase
    end
  end

  assign sda_o = 1'b0;
endmodule

/* test/gas_out_checker.sv */
// port-level assertions for the gas sensor output block
`timescale 1ns/100ps
`include "gas_out_params.svh"
module gas_out_checker #(
  parameter int MS_CYCLES = 10,
  parameter int FRAME_MS = 3,
  parameter int PWM_SPAN = 1000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire gas_out_pkg::sample_s sample,
  input wire gas_out_pkg::alarm_cfg_s alarm_cfg,
  input wire logic uart_txd,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic pwm_out,
  input wire logic alarm_o,
  input wire logic alarm_oe
);
  import gas_out_pkg::*;
  localparam int BIT_CYC = `CLK_HZ / `UART_BAUD;
  localparam int FIRST = FRAME_MS * MS_CYCLES;
  localparam int PERIOD = `PWM_PERIOD_MS * MS_CYCLES;
  localparam int HI_MIN = `PWM_START_MS * MS_CYCLES;
  localparam int HI_MAX = (`PWM_START_MS + PWM_SPAN) * MS_CYCLES;
  logic txd_r;
  logic started_r;
  logic seen_r;
  logic [15:0] low_r;
  logic [31:0] since_r;
  logic [31:0] run_r;
  logic [23:0] ppm;
  assign ppm = 24'(sample.conc) * 24'h000064;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // low_r holds the length of the current txd level, run_r the time since the last pwm rise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txd_r <= 1'b1;
      low_r <= 16'h0000;
      since_r <= 32'h0;
      run_r <= 32'h0;
      seen_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      txd_r <= uart_txd;
      low_r <= (uart_txd != txd_r) ? 16'h0001 : low_r + 16'h0001;
      since_r <= since_r + 32'h1;
      run_r <= $rose(pwm_out) ? 32'h1 : run_r + 32'h1;
      seen_r <= seen_r | $rose(pwm_out);
      started_r <= started_r | $fell(uart_txd);
    end
  end
  ////////////////////////////////////////
  reset_vals_a: assert property ($rose(rst_n) |-> (uart_txd && !sda_oe && !alarm_oe) [*4])
    else $error("outputs not idle after reset");
  uart_first_a: assert property ($fell(uart_txd) && !started_r |->
    since_r >= FIRST - 1 && since_r <= FIRST + 3)
    else $error("first frame not at frame period");
  uart_bit_a: assert property ($rose(uart_txd) |-> (low_r % BIT_CYC) == 0)
    else $error("low run not whole bit times");
  alarm_on_a: assert property (sample.valid && ppm >= alarm_cfg.on_ppm |-> ##3 alarm_oe)
    else $error("alarm not raised");
  alarm_off_a: assert property (sample.valid && ppm <= alarm_cfg.off_ppm && ppm < alarm_cfg.on_ppm
    |-> ##3 !alarm_oe)
    else $error("alarm not released");
  pwm_period_a: assert property ($rose(pwm_out) && seen_r |-> run_r == PERIOD)
    else $error("pwm period wrong");
  pwm_high_a: assert property ($fell(pwm_out) |-> run_r >= HI_MIN && run_r <= HI_MAX)
    else $error("pwm high time out of span");
  sda_drive_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  open_drain_a: assert property (!sda_o && !alarm_o)
    else $error("open drain data not low");
endmodule

/* test/host_model.sv */
// host board model: uart receiver and i2c master
`timescale 1ns/100ps
module host_model #(
  parameter int MS = 10
) (
  input wire logic mclk,
  input wire logic uart_txd,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  localparam int HP = 10;
  localparam int BIT_CYC = 2604;
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  ////////////////////////////////////////
  // 8n1 receiver, mid-bit sampling; a bad stop bit drops the byte
  initial begin
    forever begin
      @(negedge uart_txd);
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        rx_b[i] = uart_txd;
      end
      repeat (BIT_CYC) @(posedge mclk);
      if (uart_txd === 1'b1) begin
        rx_q.push_back(rx_b);
      end
    end
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start;
    sda_pull = 1'b1;
    tick(HP);
    scl = 1'b0;
  endtask
  // data moves 3 cycles after scl falls so it never races the clock edge
  task automatic clk_bit(input logic pull, output logic seen);
    tick(3);
    sda_pull = pull;
    tick(HP - 3);
    scl = 1'b1;
    tick(HP / 2);
    seen = sda;
    tick(HP / 2);
    scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(!b[i], s);
    end
    clk_bit(1'b0, s);
    ack = !s;
  endtask
  task automatic get(output logic [7:0] b, input logic nack);
    logic s;
    tick(MS);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, b[i]);
    end
    clk_bit(!nack, s);
  endtask
  task automatic stop;
    tick(3);
    sda_pull = 1'b1;
    tick(HP - 3);
    scl = 1'b1;
    tick(HP);
    sda_pull = 1'b0;
    tick(HP);
  endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the gas sensor output block
`timescale 1ns/100ps
module tb_top;
  import gas_out_pkg::*;
  localparam int MS = 10;
  logic mclk;
  logic rst_n;
  logic ppm_mode;
  sample_s sample;
  pwm_cfg_s pwm_cfg;
  alarm_cfg_s alarm_cfg;
  logic uart_txd, scl, sda, sda_pull, sda_o, sda_oe, pwm_out, alarm_o, alarm_oe;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] rd_exp [7] = '{8'h08, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00};
  // sda has a pull-up: low while either side sinks it
  assign sda = !(sda_pull || sda_oe);
  gas_out_top #(.MS_CYCLES(MS), .FRAME_MS(3), .PWM_SPAN(1000)) u_gas_out_top (
    .mclk(mclk), .rst_n(rst_n), .sample(sample), .ppm_mode(ppm_mode), .pwm_cfg(pwm_cfg),
    .alarm_cfg(alarm_cfg), .uart_txd(uart_txd), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .pwm_out(pwm_out), .alarm_o(alarm_o), .alarm_oe(alarm_oe));
  host_model #(.MS(MS)) u_host_model (
    .mclk(mclk), .uart_txd(uart_txd), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    note(got === exp, {31'h0, got}, {31'h0, exp});
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, {24'h0, got}, {24'h0, exp});
  endtask
  task automatic chk_width(input int got, input int exp);
    note(got == exp, got, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // samples are spaced so each alarm update lands before the next one
  task automatic alarm_step(input logic [15:0] c, input logic exp);
    sample = '{1'b1, c};
    @(negedge mclk);
    sample.valid = 1'b0;
    repeat (3) @(negedge mclk);
    chk_bit(alarm_oe, exp);
  endtask
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (pwm_out === v && n < 25000) begin
      @(negedge mclk);
      n++;
    end
  endtask
  ////////////////////////////////////////
  task automatic uart_part;
    for (int i = 0; i < 60000 && u_host_model.rx_q.size() < 2; i++) begin
      @(negedge mclk);
    end
    chk_byte(u_host_model.rx_q[0], 8'h20);
    chk_byte(u_host_model.rx_q[1], 8'h30);
  endtask
  task automatic i2c_part;
    logic ack;
    logic [7:0] b;
    u_host_model.start;
    u_host_model.put(8'h64, ack);
    chk_bit(ack, 1'b0);
    u_host_model.stop;
    u_host_model.start;
    u_host_model.put(8'h62, ack);
    chk_bit(ack, 1'b1);
    u_host_model.put(8'h52, ack);
    chk_bit(ack, 1'b1);
    u_host_model.stop;
    u_host_model.start;
    u_host_model.put(8'h63, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < 7; i++) begin
      u_host_model.get(b, i == 6);
      chk_byte(b, rd_exp[i]);
    end
    u_host_model.stop;
  endtask
  // 6000 ppm in a 10000 ppm range: 2 ms plus 600 ms high
  task automatic pwm_part;
    int n;
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk_width(n, 602 * MS);
    run_len(1'b0, n);
    chk_width(n, (2000 - 602) * MS);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ppm_mode = 1'b0;
    sample = '0;
    pwm_cfg = '{2'h3, 1'b0};
    alarm_cfg = '{24'h002710, 24'h001F40};
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    chk_bit(uart_txd, 1'b1);
    repeat (3) @(negedge mclk);
    alarm_step(16'h0096, 1'b1);
    alarm_step(16'h005A, 1'b1);
    alarm_step(16'h0050, 1'b0);
    alarm_cfg = '{24'h001388, 24'h000FA0};
    alarm_step(16'h003C, 1'b1);
    fork
      uart_part;
      i2c_part;
      pwm_part;
    join
    wrap_up;
  end
  // the longest thread needs about 51000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up;
    end
  end
endmodule
bind gas_out_top gas_out_checker #(.MS_CYCLES(MS_CYCLES), .FRAME_MS(FRAME_MS),
  .PWM_SPAN(PWM_SPAN)) u_gas_out_checker (.mclk(mclk), .rst_n(rst_n), .sample(sample),
  .alarm_cfg(alarm_cfg), .uart_txd(uart_txd), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .pwm_out(pwm_out), .alarm_o(alarm_o), .alarm_oe(alarm_oe));
